// ==== design/dpt_top.sv ====
// Purpose: Two-channel 8/16-bit pulse generator with APB registers
// Assumes: APB4 slave, zero wait states, all inputs synchronous
// Notes:   Pins [0] ch0 first, [1] ch0 second, [2] ch1 first, [3] ch1 second
`timescale 1ns/100ps
`default_nettype none
`include "dpt_params.svh"

// Contract
// - Ch0 second pin: GPIO or ch0 pulse
// - Ch1 second pin: GPIO or ch1 pulse
// - Ch0 clock select bits 4..2
// - Ch1 clock select bits 7..5
// - Sources: five dividers or timebase
// - Ch1 select used only in independent mode and in mode code 2
// - Two 8-bit reloads per channel
// - Independent interrupts in 8-bit modes
// - Flag set on 00 to FF step
// - Request while flag and enable set
// - Cascade request if either enable set
// - Flags clear on 0, 1 no effect
// - Alternate reloads, invert output each reload
// - Phase lasts reload plus one ticks
// - Run cleared: counter stops, output low
module dpt_top (
    input  wire logic              clk_in,
    input  wire logic              rstn_in,
    input  wire logic              tb_tick_in,
    input  wire logic [11:0]       paddr_in,
    input  wire logic              psel_in,
    input  wire logic              penable_in,
    input  wire logic              pwrite_in,
    input  wire logic [31:0]       pwdata_in,
    input  wire logic [3:0]        pstrb_in,
    output logic [31:0]            prdata_out,
    output logic                   pready_out,
    output logic                   pslverr_out,
    input  wire dpt_pkg::dpt_pins_t gpio_dout_in,
    input  wire dpt_pkg::dpt_pins_t gpio_oe_in,
    output dpt_pkg::dpt_pins_t     pin_out,
    output dpt_pkg::dpt_pins_t     pin_oe_out,
    output logic                   irq0_out,
    output logic                   irq1_out
);
    import dpt_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    logic [1:0] rst_sync_q;
    logic       rst_n;

    // Release is synchronised; assertion is immediate
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rst_sync_q <= 2'b00;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n);

    ////////////////////////////////////////////////////////////////////////
    dpt_tick_if tk ();

    dpt_presc u_presc (
        .clk_in     (clk_in),
        .rstn_in    (rst_n),
        .tb_tick_in (tb_tick_in),
        .tk         (tk.src)
    );

    ////////////////////////////////////////////////////////////////////////
    logic [7:0] ctrl0_q, ctrl0_d, ctrl1_q, ctrl1_d;
    logic [7:0] output_and_clock_select_q, output_and_clock_select_d;
    logic [7:0] ch0_low_reload_q, ch0_low_reload_d;
    logic [7:0] ch0_high_reload_q, ch0_high_reload_d;
    logic [7:0] ch1_low_reload_q, ch1_low_reload_d;
    logic [7:0] ch1_high_reload_q, ch1_high_reload_d;
    logic [1:0] flag_q, flag_d;
    logic [31:0] rdata_q, rdata_d;
    logic [1:0] mode;
    logic [1:0] run, ie, uf;
    logic       wr;
    logic [2:0] hit_w;

    // Register index: 0..3 mapped, 4 unmapped
    function automatic logic [2:0] dec(input logic [11:0] a);
        case (a)
            `DPT_OFF_CTRL0:  dec = 3'h0;
            `DPT_OFF_CTRL1:  dec = 3'h1;
            `DPT_OFF_OCSEL:  dec = 3'h2;
            `DPT_OFF_RELOAD: dec = 3'h3;
            default:         dec = 3'h4;
        endcase
    endfunction

    assign mode = ctrl1_q[`DPT_CTL_MODE_HI:`DPT_CTL_MODE_LO];
    assign run  = {ctrl1_q[`DPT_CTL_RUN], ctrl0_q[`DPT_CTL_RUN]};
    assign ie   = {ctrl1_q[`DPT_CTL_IE], ctrl0_q[`DPT_CTL_IE]};
    assign wr   = psel_in & penable_in & pwrite_in;
    assign hit_w = dec(paddr_in);

    assign pready_out  = 1'b1;
    assign pslverr_out = psel_in & penable_in & (hit_w == 3'h4);
    assign prdata_out  = rdata_q;

    always_comb begin
        ctrl0_d = ctrl0_q;
        ctrl1_d = ctrl1_q;
        output_and_clock_select_d = output_and_clock_select_q;
        ch0_low_reload_d  = ch0_low_reload_q;
        ch0_high_reload_d = ch0_high_reload_q;
        ch1_low_reload_d  = ch1_low_reload_q;
        ch1_high_reload_d = ch1_high_reload_q;
        flag_d  = flag_q;
        rdata_d = rdata_q;
        if (psel_in && !penable_in) begin
            case (hit_w)
                3'h0:    rdata_d = {24'h0, ctrl0_q[7:4], flag_q[0], 3'h0};
                3'h1:    rdata_d = {24'h0, ctrl1_q[7:4], flag_q[1], ctrl1_q[2:1], 1'b0};
                3'h2:    rdata_d = {24'h0, output_and_clock_select_q};
                3'h3:    rdata_d = {ch1_high_reload_q, ch1_low_reload_q,
                                    ch0_high_reload_q, ch0_low_reload_q};
                default: rdata_d = 32'h0;
            endcase
        end
        if (wr && pstrb_in[0]) begin
            case (hit_w)
                3'h0: begin
                    ctrl0_d = {pwdata_in[7], 1'b0, pwdata_in[5:4], 4'h0};
                    if (!pwdata_in[`DPT_CTL_FLAG]) flag_d[0] = 1'b0;
                end
                3'h1: begin
                    ctrl1_d = {pwdata_in[7], 1'b0, pwdata_in[5:4], 1'b0,
                               pwdata_in[2:1], 1'b0};
                    if (!pwdata_in[`DPT_CTL_FLAG]) flag_d[1] = 1'b0;
                end
                3'h2: output_and_clock_select_d = pwdata_in[7:0];
                3'h3: ch0_low_reload_d = pwdata_in[7:0];
                default: ;
            endcase
        end
        if (wr && hit_w == 3'h3) begin
            if (pstrb_in[1]) ch0_high_reload_d = pwdata_in[15:8];
            if (pstrb_in[2]) ch1_low_reload_d  = pwdata_in[23:16];
            if (pstrb_in[3]) ch1_high_reload_d = pwdata_in[31:24];
        end
        // Set wins over a clear in the same cycle
        flag_d = flag_d | uf;
    end

    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            ctrl0_q <= `DPT_RST_BYTE;
            ctrl1_q <= `DPT_RST_BYTE;
            output_and_clock_select_q <= `DPT_RST_BYTE;
            ch0_low_reload_q  <= `DPT_RST_RELOAD;
            ch0_high_reload_q <= `DPT_RST_RELOAD;
            ch1_low_reload_q  <= `DPT_RST_RELOAD;
            ch1_high_reload_q <= `DPT_RST_RELOAD;
            flag_q  <= 2'b00;
            rdata_q <= 32'h0;
        end else begin
            ctrl0_q <= ctrl0_d;
            ctrl1_q <= ctrl1_d;
            output_and_clock_select_q <= output_and_clock_select_d;
            ch0_low_reload_q  <= ch0_low_reload_d;
            ch0_high_reload_q <= ch0_high_reload_d;
            ch1_low_reload_q  <= ch1_low_reload_d;
            ch1_high_reload_q <= ch1_high_reload_d;
            flag_q  <= flag_d;
            rdata_q <= rdata_d;
        end
    end

    // Each channel asks on its own flag; in cascade both flags rise at once
    assign irq0_out = flag_q[0] & ie[0];
    assign irq1_out = flag_q[1] & ie[1];

    ////////////////////////////////////////////////////////////////////////
    logic [7:0] cnt_q [2];
    logic [7:0] cnt_d [2];
    dpt_phase_t ph_q [2];
    dpt_phase_t ph_d [2];
    logic [7:0] rl_lo [2];
    logic [7:0] rl_hi [2];
    logic [1:0] tick;
    logic       casc;

    assign tk.sel0 = output_and_clock_select_q[`DPT_OC_SEL0_LO +: 3];
    assign tk.sel1 = output_and_clock_select_q[`DPT_OC_SEL1_LO +: 3];
    assign rl_lo[0] = ch0_low_reload_q;
    assign rl_lo[1] = ch1_low_reload_q;
    assign rl_hi[0] = ch0_high_reload_q;
    assign rl_hi[1] = ch1_high_reload_q;
    assign casc = (mode == `DPT_MODE_CASC16);

    // 8+8 uses ch0 underflow as the ch1 count clock; 16-bit uses ch0 clock
    always_comb begin
        tick[0] = tk.tick0;
        case (mode)
            `DPT_MODE_EIGHT8: tick[1] = uf[0];
            `DPT_MODE_CASC16: tick[1] = tk.tick0;
            default:          tick[1] = tk.tick1;
        endcase
    end

    always_comb begin
        cnt_d = cnt_q;
        ph_d  = ph_q;
        uf    = 2'b00;
        if (casc) begin
            if (!(&run)) begin
                cnt_d[0] = rl_lo[0];
                cnt_d[1] = rl_lo[1];
                ph_d[0] = DPT_LOW;
                ph_d[1] = DPT_LOW;
            end else if (tick[0]) begin
                if ({cnt_q[1], cnt_q[0]} == {`DPT_CNT_ZERO, `DPT_CNT_ZERO}) begin
                    uf = 2'b11;
                    ph_d[0] = (ph_q[0] == DPT_LOW) ? DPT_HIGH : DPT_LOW;
                    ph_d[1] = ph_d[0];
                    cnt_d[0] = (ph_d[0] == DPT_HIGH) ? rl_hi[0] : rl_lo[0];
                    cnt_d[1] = (ph_d[0] == DPT_HIGH) ? rl_hi[1] : rl_lo[1];
                end else begin
                    {cnt_d[1], cnt_d[0]} = {cnt_q[1], cnt_q[0]} - 16'h1;
                end
            end
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (!run[i]) begin
                    cnt_d[i] = rl_lo[i];
                    ph_d[i]  = DPT_LOW;
                end else if ((i == 0) ? tick[0] : tick[1]) begin
                    if (cnt_q[i] == `DPT_CNT_ZERO) begin
                        uf[i] = 1'b1;
                        ph_d[i] = (ph_q[i] == DPT_LOW) ? DPT_HIGH : DPT_LOW;
                        cnt_d[i] = (ph_d[i] == DPT_HIGH) ? rl_hi[i] : rl_lo[i];
                    end else begin
                        cnt_d[i] = cnt_q[i] - 8'h1;
                    end
                end
            end
        end
    end

    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q[0] <= `DPT_CNT_ZERO;
            cnt_q[1] <= `DPT_CNT_ZERO;
            ph_q[0]  <= DPT_LOW;
            ph_q[1]  <= DPT_LOW;
        end else begin
            cnt_q <= cnt_d;
            ph_q  <= ph_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    dpt_pins_t en, src, pin_d, pin_q, oe_d, oe_q;
    logic [1:0] pulse;

    assign pulse[0] = run[0] & (ph_q[0] == DPT_HIGH);
    assign pulse[1] = casc ? pulse[0] : run[1] & (ph_q[1] == DPT_HIGH);
    assign en  = {output_and_clock_select_q[`DPT_OC_SEC1], ctrl1_q[`DPT_CTL_PIN],
                  output_and_clock_select_q[`DPT_OC_SEC0], ctrl0_q[`DPT_CTL_PIN]};
    assign src = {pulse[1], pulse[1], pulse[0], pulse[0]};

    always_comb begin
        pin_d = gpio_dout_in;
        oe_d  = gpio_oe_in;
        for (int p = 0; p < 4; p++) begin
            if (en[p]) begin
                pin_d[p] = src[p];
                oe_d[p]  = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            pin_q <= 4'h0;
            oe_q  <= 4'h0;
        end else begin
            pin_q <= pin_d;
            oe_q  <= oe_d;
        end
    end

    assign pin_out    = pin_q;
    assign pin_oe_out = oe_q;

    ////////////////////////////////////////////////////////////////////////
    sequence s_low_uf0;
        !casc && uf[0] && ph_q[0] == DPT_LOW;
    endsequence

    sequence s_high_loaded0;
        ph_q[0] == DPT_HIGH && cnt_q[0] == $past(ch0_high_reload_q);
    endsequence

    a_reload_alt: assert property (s_low_uf0 |=> s_high_loaded0)
        else $error("High reload not taken after low phase underflow");

    a_flag_set: assert property (uf[1] |=> flag_q[1])
        else $error("Underflow did not set channel 1 flag");

    a_casc_both: assert property (casc && uf[0] |=> flag_q == 2'b11)
        else $error("Cascade underflow did not set both flags");

    a_stop_low: assert property (!run[0] ##1 !run[0] |-> ph_q[0] == DPT_LOW
                                 && cnt_q[0] == $past(ch0_low_reload_q))
        else $error("Stopped channel not held low");

    a_pin_pulse: assert property (en[1] |=> pin_q[1] == $past(pulse[0])
                                  && oe_q[1])
        else $error("Second ch0 pin not driving pulse");

    a_pin_gpio: assert property (!en[3] |=> pin_q[3] == $past(gpio_dout_in[3])
                                 && oe_q[3] == $past(gpio_oe_in[3]))
        else $error("Second ch1 pin not routed to port");

    a_irq_req: assert property (flag_q[0] && ie[0] |-> irq0_out)
        else $error("Missing channel 0 request");

    a_flag_clear: assert property (wr && pstrb_in[0] && hit_w == 3'h0
                                   && !pwdata_in[`DPT_CTL_FLAG] && !uf[0]
                                   |=> !flag_q[0])
        else $error("Flag not cleared by zero write");

    // Own select must not leak in: ch1 only moves on a ch0 underflow
    a_ch1_clock: assert property (mode == `DPT_MODE_EIGHT8 && run[1] && !uf[0]
                                  |=> cnt_q[1] == $past(cnt_q[1]))
        else $error("Channel 1 counted without channel 0 underflow");

    a_count_step: assert property (!casc && run[0] && tick[0] && cnt_q[0] != `DPT_CNT_ZERO
                                   |=> cnt_q[0] == $past(cnt_q[0]) - 8'h1)
        else $error("Down counter step wrong");

    a_div2_strobe: assert property (tk.sel0 == `DPT_CK_DIV2 && tk.tick0
                                    ##1 tk.sel0 == `DPT_CK_DIV2 |-> !tk.tick0)
        else $error("Divide-by-2 strobe wider than one cycle");
endmodule
`default_nettype wire

// ==== design/dpt_params.svh ====
// Purpose: Offsets, field positions and codes of the dual pulse timer
// Assumes: 32-bit APB, one register per aligned word
// Notes:   Definitions only
`ifndef DPT_PARAMS_SVH
`define DPT_PARAMS_SVH

`define DPT_OFF_CTRL0    12'h000
`define DPT_OFF_CTRL1    12'h004
`define DPT_OFF_OCSEL    12'h008
`define DPT_OFF_RELOAD   12'h00c

`define DPT_CTL_RUN      7
`define DPT_CTL_PIN      5
`define DPT_CTL_IE       4
`define DPT_CTL_FLAG     3
`define DPT_CTL_MODE_HI  2
`define DPT_CTL_MODE_LO  1

`define DPT_OC_SEC0      0
`define DPT_OC_SEC1      1
`define DPT_OC_SEL0_LO   2
`define DPT_OC_SEL1_LO   5

`define DPT_MODE_INDEP   2'h0
`define DPT_MODE_EIGHT8  2'h1
`define DPT_MODE_CASC16  2'h3

`define DPT_CK_DIV1      3'h0
`define DPT_CK_DIV2      3'h1
`define DPT_CK_DIV4      3'h2
`define DPT_CK_DIV8      3'h3
`define DPT_CK_DIV16     3'h4
`define DPT_CK_TBASE     3'h7

`define DPT_RST_BYTE     8'h00
`define DPT_RST_RELOAD   8'h00
`define DPT_CNT_ZERO     8'h00

`endif

// ==== design/dpt_pkg.sv ====
// Purpose: Types shared by the dual pulse timer files
// Assumes: Nothing
// Notes:   Numbers live in dpt_params.svh
package dpt_pkg;
    typedef enum logic {DPT_LOW, DPT_HIGH} dpt_phase_t;
    typedef logic [3:0] dpt_pins_t;
endpackage

// ==== design/dpt_tick_if.sv ====
// Purpose: Count clock select and strobes between top and prescaler
// Assumes: One clock domain
// Notes:   Strobes are one machine-clock cycle wide
`timescale 1ns/100ps
`default_nettype none
interface dpt_tick_if;
    logic [2:0] sel0;
    logic [2:0] sel1;
    logic       tick0;
    logic       tick1;
    modport src (input sel0, input sel1, output tick0, output tick1);
    modport usr (output sel0, output sel1, input tick0, input tick1);
endinterface
`default_nettype wire

// ==== design/dpt_presc.sv ====
// Purpose: Free-running prescaler giving count clock strobes
// Assumes: Timebase strobe is synchronous and one cycle wide
// Notes:   Reserved select codes fall back to divide by 16
`timescale 1ns/100ps
`default_nettype none
`include "dpt_params.svh"
module dpt_presc (
    input  wire logic    clk_in,
    input  wire logic    rstn_in,
    input  wire logic    tb_tick_in,
    dpt_tick_if.src      tk
);
    import dpt_pkg::*;

    logic [3:0] pre_q;
    logic [3:0] pre_d;
    logic [4:0] div;

    // A strobe rather than a derived clock keeps all counting in one domain
    function automatic logic pick(input logic [2:0] s, input logic [4:0] d,
                                  input logic tb);
        case (s)
            `DPT_CK_DIV1:  pick = d[0];
            `DPT_CK_DIV2:  pick = d[1];
            `DPT_CK_DIV4:  pick = d[2];
            `DPT_CK_DIV8:  pick = d[3];
            `DPT_CK_DIV16: pick = d[4];
            `DPT_CK_TBASE: pick = tb;
            default:       pick = d[4];
        endcase
    endfunction

    always_comb begin
        pre_d = pre_q + 4'h1;
        div[0] = 1'b1;
        div[1] = pre_q[0];
        div[2] = &pre_q[1:0];
        div[3] = &pre_q[2:0];
        div[4] = &pre_q[3:0];
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            pre_q <= 4'h0;
        end else begin
            pre_q <= pre_d;
        end
    end

    assign tk.tick0 = pick(tk.sel0, div, tb_tick_in);
    assign tk.tick1 = pick(tk.sel1, div, tb_tick_in);
endmodule
`default_nettype wire

// ==== verification/dpt_load.sv ====
// Purpose: Load on one pulse pin that measures its level widths
// Assumes: Pin sampled on the machine clock
// Notes:   Widths are in machine-clock cycles
`timescale 1ns/100ps
`default_nettype none
module dpt_load (
    input  wire logic        clk_in,
    input  wire logic        rstn_in,
    input  wire logic        pin_in,
    output logic [15:0]      hi_len_out,
    output logic [15:0]      lo_len_out,
    output logic [15:0]      rises_out
);
    logic [15:0] len_q;
    logic        last_q;
    // Booked only at an edge, so a stopped pin never shows a partial phase
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            len_q      <= 16'h0001;
            last_q     <= 1'b0;
            hi_len_out <= 16'h0000;
            lo_len_out <= 16'h0000;
            rises_out  <= 16'h0000;
        end else if (pin_in !== last_q) begin
            len_q  <= 16'h0001;
            last_q <= pin_in;
            if (last_q)
                hi_len_out <= len_q;
            else
                lo_len_out <= len_q;
            if (pin_in)
                rises_out <= rises_out + 16'h0001;
        end else begin
            len_q <= len_q + 16'h0001;
        end
    end
endmodule
`default_nettype wire

// ==== verification/dual_pulse_timer_clock_reload_irq_bench.sv ====
// Purpose: Self-checking bench of the dual pulse timer
// Assumes: Zero-wait APB slave may still stretch, master waits for pready
// Notes:   Pulse widths come from two load models on the first pins
`timescale 1ns/100ps
`default_nettype none
`include "dpt_params.svh"
module dual_pulse_timer_clock_reload_irq_bench;
    import dpt_pkg::*;
    localparam int          TBP = 5;
    localparam logic [31:0] RUN = 32'h1 << `DPT_CTL_RUN;
    localparam logic [31:0] PIN = 32'h1 << `DPT_CTL_PIN;
    localparam logic [31:0] IE  = 32'h1 << `DPT_CTL_IE;
    localparam logic [31:0] FLG = 32'h1 << `DPT_CTL_FLAG;
    logic        clk_in = 1'b0;
    logic        rstn_in = 1'b0;
    logic        tb_tick = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    dpt_pins_t   gdout = 4'h0;
    dpt_pins_t   goe = 4'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    dpt_pins_t   pin;
    dpt_pins_t   pin_oe;
    logic        irq0;
    logic        irq1;
    logic [15:0] hi0, lo0, r0, hi1, lo1, r1;
    logic [31:0] seed = 32'h0000001e;
    int          tb_cnt = 0;
    int          fails = 0;
    int          n_checks = 0;
    always #10 clk_in = ~clk_in;
    always @(posedge clk_in) begin
        tb_cnt  <= (tb_cnt == TBP - 1) ? 0 : tb_cnt + 1;
        tb_tick <= (tb_cnt == TBP - 1);
    end
    dpt_top dpt_top_inst (.clk_in(clk_in), .rstn_in(rstn_in), .tb_tick_in(tb_tick),
        .paddr_in(paddr), .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
        .pwdata_in(pwdata), .pstrb_in(4'hf), .prdata_out(prdata), .pready_out(pready),
        .pslverr_out(pslverr), .gpio_dout_in(gdout), .gpio_oe_in(goe), .pin_out(pin),
        .pin_oe_out(pin_oe), .irq0_out(irq0), .irq1_out(irq1));
    dpt_load dpt_load_inst0 (.clk_in(clk_in), .rstn_in(rstn_in), .pin_in(pin[0]),
        .hi_len_out(hi0), .lo_len_out(lo0), .rises_out(r0));
    dpt_load dpt_load_inst1 (.clk_in(clk_in), .rstn_in(rstn_in), .pin_in(pin[2]),
        .hi_len_out(hi1), .lo_len_out(lo1), .rises_out(r1));
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] wid(input logic [2:0] c, input logic [15:0] r);
        int d;
        d = (c == `DPT_CK_TBASE) ? TBP : (c > `DPT_CK_DIV16) ? 16 : (1 << c);
        return (r + 1) * d;
    endfunction
    function automatic void rnd(output logic [31:0] v);
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        v = seed;
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string s);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR at %0t: %s seen %h expected %h", $time, s, seen, exp);
        end
    endtask
    task automatic results;
        $display("Counts: %0d checks, %0d mismatches", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // Request held until pready is seen high at a rising edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] rv, output logic e);
        int k;
        @(posedge clk_in);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk_in);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clk_in);
            k++;
        end while (pready !== 1'b1 && k < 50);
        if (k >= 50)
            check(0, 1, "apb hang");
        rv = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_in);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] rv;
        logic        e;
        apb(1'b1, a, d, rv, e);
    endtask
    task automatic rdc(input logic [11:0] a, input logic [31:0] m, input logic [31:0] x);
        logic [31:0] rv;
        logic        e;
        apb(1'b0, a, 32'h0, rv, e);
        check(rv & m, x, "register read");
    endtask
    task automatic rises(input bit ch, input int n);
        logic [15:0] s;
        int          k;
        s = ch ? r1 : r0;
        k = 0;
        while (((ch ? r1 : r0) - s) < n && k < 20000) begin
            @(posedge clk_in);
            k++;
        end
        if (k >= 20000)
            check(0, 1, "no pulse edges");
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        #1500000;
        fails++;
        results();
    end
    initial begin
        logic [2:0]  codes [8];
        logic [7:0]  l0, h0, l1, h1;
        logic [31:0] v;
        logic        e;
        int          j;
        codes = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h7, 3'h5, 3'h6};
        repeat (5) @(posedge clk_in);
        rstn_in <= 1'b1;
        repeat (3) @(posedge clk_in);
        check(pin_oe, 4'h0, "pin enables after reset");
        rdc(`DPT_OFF_OCSEL, 32'hff, 32'h0);
        rdc(`DPT_OFF_RELOAD, 32'hffffffff, 32'h0);
        apb(1'b0, 12'h010, 32'h0, v, e);
        check(e, 1'b1, "unmapped error");
        rnd(v);
        wr(`DPT_OFF_RELOAD, v);
        rdc(`DPT_OFF_RELOAD, 32'hffffffff, v);
        $display("test reset_and_map done");
        foreach (codes[i]) begin
            j = (i + 3) % 8;
            rnd(v);
            l0 = (i == 0) ? 8'hff : {6'h0, v[1:0]};
            h0 = (i == 0) ? 8'h00 : {6'h0, v[3:2]};
            l1 = {6'h0, v[5:4]};
            h1 = {6'h0, v[7:6]};
            wr(`DPT_OFF_CTRL0, 32'h0);
            wr(`DPT_OFF_CTRL1, 32'h0);
            wr(`DPT_OFF_OCSEL, {24'h0, codes[j], codes[i], 2'b00});
            wr(`DPT_OFF_RELOAD, {h1, l1, h0, l0});
            wr(`DPT_OFF_CTRL0, RUN | PIN);
            wr(`DPT_OFF_CTRL1, RUN | PIN | ((i % 2) << `DPT_CTL_MODE_HI));
            rises(1'b0, 3);
            check({16'h0, lo0}, wid(codes[i], l0), "ch0 low width");
            check({16'h0, hi0}, wid(codes[i], h0), "ch0 high width");
            rises(1'b1, 3);
            check({16'h0, lo1}, wid(codes[j], l1), "ch1 low width");
            check({16'h0, hi1}, wid(codes[j], h1), "ch1 high width");
        end
        $display("test clock_select done");
        rnd(v);
        @(posedge clk_in);
        gdout <= v[3:0];
        goe   <= v[7:4];
        wr(`DPT_OFF_OCSEL, 32'h0);
        repeat (3) @(posedge clk_in);
        check({pin[3], pin[1], pin_oe[3], pin_oe[1]}, {v[3], v[1], v[7], v[5]}, "gpio");
        wr(`DPT_OFF_OCSEL, 32'h3);
        repeat (40) begin
            @(posedge clk_in);
            check({pin[1], pin[3], pin_oe[1], pin_oe[3]}, {pin[0], pin[2], 2'b11}, "pin");
        end
        $display("test second_pins done");
        // First pass stops both channels, second clears flags no underflow can race
        repeat (2) begin
            wr(`DPT_OFF_CTRL0, 32'h0);
            wr(`DPT_OFF_CTRL1, 32'h0);
        end
        rdc(`DPT_OFF_CTRL0, FLG, 32'h0);
        wr(`DPT_OFF_CTRL0, RUN | PIN);
        rises(1'b0, 2);
        check(irq0, 1'b0, "masked request");
        rdc(`DPT_OFF_CTRL0, FLG, FLG);
        rdc(`DPT_OFF_CTRL1, FLG, 32'h0);
        wr(`DPT_OFF_CTRL0, RUN | PIN | IE | FLG);
        check(irq0, 1'b1, "request raised");
        check(irq1, 1'b0, "other request");
        wr(`DPT_OFF_CTRL0, PIN | IE | FLG);
        // A rise launched at the stopping edge is still being booked
        repeat (3) @(posedge clk_in);
        v = r0;
        repeat (60) @(posedge clk_in);
        check({pin[0], r0}, {1'b0, v[15:0]}, "stopped pin");
        check(irq0, 1'b1, "flag kept on write of one");
        wr(`DPT_OFF_CTRL0, PIN | IE);
        check(irq0, 1'b0, "request cleared");
        rdc(`DPT_OFF_CTRL0, FLG, 32'h0);
        $display("test flags done");
        wr(`DPT_OFF_CTRL0, 32'h0);
        wr(`DPT_OFF_RELOAD, {8'h01, 8'h02, 8'h01, 8'h01});
        wr(`DPT_OFF_OCSEL, {24'h0, 3'h0, 3'h1, 2'b00});
        wr(`DPT_OFF_CTRL0, RUN | PIN);
        wr(`DPT_OFF_CTRL1, RUN | PIN | (32'h1 << 1));
        for (int k = 0; k < 2; k++) begin
            rises(1'b1, 3);
            check({16'h0, lo1}, 32'd12, "8+8 ch1 low width");
            check({16'h0, hi1}, 32'd8, "8+8 ch1 high width");
            wr(`DPT_OFF_OCSEL, {24'h0, 3'h7, 3'h1, 2'b00});
        end
        $display("test eight_plus_eight done");
        wr(`DPT_OFF_CTRL0, 32'h0);
        wr(`DPT_OFF_CTRL1, 32'h0);
        wr(`DPT_OFF_OCSEL, 32'h3);
        wr(`DPT_OFF_RELOAD, {8'h00, 8'h01, 8'h05, 8'h02});
        wr(`DPT_OFF_CTRL1, RUN | PIN | IE | (32'h3 << 1));
        wr(`DPT_OFF_CTRL0, RUN | PIN);
        rises(1'b0, 3);
        check({16'h0, lo0}, 32'd259, "cascade low width");
        check({16'h0, hi0}, 32'd6, "cascade high width");
        check({irq1, irq0}, 2'b10, "cascade request");
        check({pin_oe, pin}, {4'hf, {4{pin[0]}}}, "cascade pins");
        rdc(`DPT_OFF_CTRL0, FLG, FLG);
        rdc(`DPT_OFF_CTRL1, FLG, FLG);
        wr(`DPT_OFF_CTRL1, 32'h0);
        wr(`DPT_OFF_CTRL0, 32'h0);
        wr(`DPT_OFF_CTRL1, 32'h0);
        rdc(`DPT_OFF_CTRL0, FLG, 32'h0);
        rdc(`DPT_OFF_CTRL1, FLG, 32'h0);
        $display("test cascade done");
        results();
    end
endmodule
`default_nettype wire
